// >>> rtl/rpc_pkg.sv
// Constants and carrier types for the reset and power control block.
// Assumes a single 125 MHz clock and a plain one-cycle register port.
// Summary of operation
// - Sleep-off bit set only by timed unlock
// - Sleep-off bit active three cycles after set
// - Sleep-off bit self-clears three cycles later
// - Sleep while active turns detector off
// - Sleep-off bit 6, unlock bit 5
// - Gate bits 7 to 5 read zero
// - Gate bit 4 stops display controller
// - Gate bit 3 freezes 16-bit timer
// - Gate bit 2 stops serial peripheral clock
// - Gate bit 1 stops transceiver clock
// - Gate bit 0 stops converter, blocks mux
// - Reset loads registers, core restarts
// - Port reset immediate with no clock for power, pin, brown-out and scan; watchdog sets it on a clock edge
// - Delay counter stretches reset per fuses
// - Internal reset merges five sources
// - Scan reset holds while register set
// - Power loss resets at once
// - Long low pin resets without clock
// - Brown-out resets at once when enabled
// - Watchdog one-cycle pulse, delay after fall
// - Bandgap on for detector, comparator, converter
// - Per-source flags, write zero clears
package rpc_pkg;

    localparam logic [7:0] ADDR_CORE_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_CLOCK_GATE = 8'h01;
    localparam logic [7:0] ADDR_RESET_CAUSE = 8'h02;

    localparam int BIT_SLEEP_OFF = 6;
    localparam int BIT_SLEEP_UNLOCK = 5;
    localparam int BIT_GATE_DISPLAY = 4;
    localparam int BIT_GATE_TIMER16 = 3;
    localparam int BIT_GATE_SPI = 2;
    localparam int BIT_GATE_XCVR = 1;
    localparam int BIT_GATE_CONV = 0;
    localparam int BIT_FLAG_POR = 0;
    localparam int BIT_FLAG_EXT = 1;
    localparam int BIT_FLAG_BOD = 2;
    localparam int BIT_FLAG_WDT = 3;
    localparam int BIT_FLAG_SCAN = 4;

    localparam logic [4:0] GATE_RESET = 5'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h01;

    // Unlock window and arm/active counter reloads; each phase lasts one cycle more
    localparam logic [1:0] UNLOCK_CYCLES = 2'h3;
    localparam logic [1:0] ARM_CYCLES = 2'h1;
    localparam logic [1:0] ACTIVE_CYCLES = 2'h2;

    // Reset stretch per start-up fuse, or for the external clock select, in cycles
    localparam logic [12:0] DELAY_SUT0 = 13'h0010;
    localparam logic [12:0] DELAY_SUT1 = 13'h0200;
    localparam logic [12:0] DELAY_SUT2 = 13'h0800;
    localparam logic [12:0] DELAY_SUT3 = 13'h1000;
    localparam logic [12:0] DELAY_EXTCLK = 13'h0006;
    localparam logic [3:0] CLOCK_SELECT_FUSE_EXTCLK = 4'h0;
    localparam logic [1:0] BROWNOUT_LEVEL_FUSE_OFF = 2'h3;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_UNLOCK,
        SEQ_ARM,
        SEQ_ACTIVE
    } rpc_seq_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } rpc_bus_req_t;

    typedef struct packed {
        logic display;
        logic timer16;
        logic serial_periph;
        logic serial_xcvr;
        logic converter;
    } rpc_gate_t;

    typedef struct packed {
        logic [1:0] ext_n_s;
        logic [1:0] bod_low_s;
        logic [1:0] scan_s;
        logic wdt_pulse;
        logic sys_reset;
        logic [12:0] delay;
        rpc_seq_t seq;
        logic [1:0] seq_cnt;
        logic detector_off;
        rpc_gate_t gate;
        logic [4:0] flags;
        logic [7:0] rdata;
        logic bandgap_en;
        logic mux_allow;
        logic por_pend;
        logic sleep_off;
    } rpc_state_t;

endpackage : rpc_pkg

// >>> rtl/rpc_reset_power.sv
// Reset combiner, reset stretcher, detector sleep-off sequence and clock gates.
// Assumes fuses are static; pins are synchronised here; watchdog on mclk.
`timescale 1ns/10ps

module rpc_reset_power (
    input wire logic mclk,
    input wire logic rst,
    input wire rpc_pkg::rpc_bus_req_t bus_req,
    output logic [7:0] rdata,
    input wire logic ext_reset_n,
    input wire logic bod_low,
    input wire logic scan_reset,
    input wire logic wdt_expire,
    input wire logic wdt_enable,
    input wire logic [1:0] brownout_level_fuse,
    input wire logic [1:0] startup_time_fuse,
    input wire logic [3:0] clock_select_fuse,
    input wire logic comparator_bandgap_select,
    input wire logic converter_enable,
    input wire logic sleep_exec,
    input wire logic sleep_wake,
    output logic port_reset,
    output logic core_reset,
    output logic brownout_sleep_off,
    output logic detector_off,
    output rpc_pkg::rpc_gate_t gate,
    output logic conv_mux_allow,
    output logic bandgap_enable
);

    rpc_pkg::rpc_state_t s_q;
    rpc_pkg::rpc_state_t s_d;
    logic port_reset_q;
    logic raw_any;
    logic bod_en;
    logic src_now;
    logic [12:0] delay_load;
    logic wr_core;
    logic wr_gate;
    logic wr_flags;
    logic [7:0] rd_mux;

    assign bod_en = (brownout_level_fuse != rpc_pkg::BROWNOUT_LEVEL_FUSE_OFF);

    // Raw sources force the port reset with no clock needed
    assign raw_any = rst | ~ext_reset_n | (bod_low & bod_en) | scan_reset;

    always_ff @(posedge mclk or posedge raw_any) begin
        if (raw_any) begin
            port_reset_q <= 1'b1;
        end else begin
            port_reset_q <= s_q.sys_reset;
        end
    end

    assign wr_core = bus_req.wr && (bus_req.addr == rpc_pkg::ADDR_CORE_CONTROL);
    assign wr_gate = bus_req.wr && (bus_req.addr == rpc_pkg::ADDR_CLOCK_GATE);
    assign wr_flags = bus_req.wr && (bus_req.addr == rpc_pkg::ADDR_RESET_CAUSE);

    // Synchronised sources combined into one level
    assign src_now = ~s_q.ext_n_s[1] | (s_q.bod_low_s[1] & bod_en) | s_q.scan_s[1]
        | s_q.wdt_pulse | s_q.por_pend;

    // Stretch length from start-up and clock-select fuses
    always_comb begin
        delay_load = rpc_pkg::DELAY_SUT0;
        if (clock_select_fuse == rpc_pkg::CLOCK_SELECT_FUSE_EXTCLK) begin
            delay_load = rpc_pkg::DELAY_EXTCLK;
        end else begin
            case (startup_time_fuse)
                2'h0: delay_load = rpc_pkg::DELAY_SUT0;
                2'h1: delay_load = rpc_pkg::DELAY_SUT1;
                2'h2: delay_load = rpc_pkg::DELAY_SUT2;
                default: delay_load = rpc_pkg::DELAY_SUT3;
            endcase
        end
    end

    // Register read mux, reserved bits zero
    always_comb begin
        rd_mux = 8'h00;
        if (bus_req.addr == rpc_pkg::ADDR_CORE_CONTROL) begin
            rd_mux[rpc_pkg::BIT_SLEEP_OFF] = (s_q.seq == rpc_pkg::SEQ_ACTIVE);
            rd_mux[rpc_pkg::BIT_SLEEP_UNLOCK] = (s_q.seq == rpc_pkg::SEQ_UNLOCK);
        end else if (bus_req.addr == rpc_pkg::ADDR_CLOCK_GATE) begin
            rd_mux = {3'h0, s_q.gate};
        end else if (bus_req.addr == rpc_pkg::ADDR_RESET_CAUSE) begin
            rd_mux = {3'h0, s_q.flags};
        end else begin
            rd_mux = 8'h00;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.ext_n_s = {s_q.ext_n_s[0], ext_reset_n};
        s_d.bod_low_s = {s_q.bod_low_s[0], bod_low};
        s_d.scan_s = {s_q.scan_s[0], scan_reset};
        // Power-on release loads the fuse-chosen stretch once
        s_d.por_pend = 1'b0;
        // Expiry becomes a single-cycle pulse
        s_d.wdt_pulse = wdt_expire & wdt_enable & ~s_q.wdt_pulse;

        // Count starts once all sources are gone
        if (src_now) begin
            s_d.delay = delay_load;
            s_d.sys_reset = 1'b1;
        end else if (s_q.delay != 13'h0000) begin
            s_d.delay = s_q.delay - 13'h0001;
            s_d.sys_reset = 1'b1;
        end else begin
            s_d.sys_reset = 1'b0;
        end

        s_d.rdata = bus_req.rd ? rd_mux : 8'h00;

        // Flags: write zero clears, source wins
        if (wr_flags) begin
            s_d.flags = s_q.flags & bus_req.wdata[4:0];
        end
        if (~s_q.ext_n_s[1]) begin
            s_d.flags[rpc_pkg::BIT_FLAG_EXT] = 1'b1;
        end
        if (s_q.bod_low_s[1] & bod_en) begin
            s_d.flags[rpc_pkg::BIT_FLAG_BOD] = 1'b1;
        end
        if (s_q.wdt_pulse) begin
            s_d.flags[rpc_pkg::BIT_FLAG_WDT] = 1'b1;
        end
        if (s_q.scan_s[1]) begin
            s_d.flags[rpc_pkg::BIT_FLAG_SCAN] = 1'b1;
        end

        if (wr_gate) begin
            s_d.gate = bus_req.wdata[4:0];
        end

        // Detector sleep-off timed sequence
        case (s_q.seq)
            rpc_pkg::SEQ_IDLE: begin
                if (wr_core && bus_req.wdata[rpc_pkg::BIT_SLEEP_OFF]
                    && bus_req.wdata[rpc_pkg::BIT_SLEEP_UNLOCK]) begin
                    s_d.seq = rpc_pkg::SEQ_UNLOCK;
                    s_d.seq_cnt = rpc_pkg::UNLOCK_CYCLES;
                end
            end
            rpc_pkg::SEQ_UNLOCK: begin
                if (wr_core && bus_req.wdata[rpc_pkg::BIT_SLEEP_OFF]
                    && !bus_req.wdata[rpc_pkg::BIT_SLEEP_UNLOCK]) begin
                    s_d.seq = rpc_pkg::SEQ_ARM;
                    s_d.seq_cnt = rpc_pkg::ARM_CYCLES;
                end else if (wr_core && bus_req.wdata[rpc_pkg::BIT_SLEEP_OFF]
                    && bus_req.wdata[rpc_pkg::BIT_SLEEP_UNLOCK]) begin
                    s_d.seq_cnt = rpc_pkg::UNLOCK_CYCLES;
                end else if (s_q.seq_cnt == 2'h0) begin
                    s_d.seq = rpc_pkg::SEQ_IDLE;
                end else begin
                    s_d.seq_cnt = s_q.seq_cnt - 2'h1;
                end
            end
            rpc_pkg::SEQ_ARM: begin
                if (s_q.seq_cnt == 2'h0) begin
                    s_d.seq = rpc_pkg::SEQ_ACTIVE;
                    s_d.seq_cnt = rpc_pkg::ACTIVE_CYCLES;
                end else begin
                    s_d.seq_cnt = s_q.seq_cnt - 2'h1;
                end
            end
            default: begin
                if (s_q.seq_cnt == 2'h0) begin
                    s_d.seq = rpc_pkg::SEQ_IDLE;
                end else begin
                    s_d.seq_cnt = s_q.seq_cnt - 2'h1;
                end
            end
        endcase

        // Sleep inside the active window turns the detector off
        if (sleep_exec && s_q.seq == rpc_pkg::SEQ_ACTIVE) begin
            s_d.detector_off = 1'b1;
        end else if (sleep_wake) begin
            s_d.detector_off = 1'b0;
        end

        s_d.bandgap_en = bod_en | comparator_bandgap_select | converter_enable;
        s_d.mux_allow = ~s_d.gate.converter;

        // Internal reset restores register defaults, flags kept
        if (s_q.sys_reset) begin
            s_d.gate = rpc_pkg::GATE_RESET;
            s_d.seq = rpc_pkg::SEQ_IDLE;
            s_d.seq_cnt = 2'h0;
            s_d.detector_off = 1'b0;
            s_d.mux_allow = 1'b1;
        end
        s_d.sleep_off = (s_d.seq == rpc_pkg::SEQ_ACTIVE);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q.ext_n_s <= 2'h3;
            s_q.bod_low_s <= 2'h0;
            s_q.scan_s <= 2'h0;
            s_q.wdt_pulse <= 1'b0;
            s_q.sys_reset <= 1'b1;
            s_q.delay <= rpc_pkg::DELAY_SUT3;
            s_q.seq <= rpc_pkg::SEQ_IDLE;
            s_q.seq_cnt <= 2'h0;
            s_q.detector_off <= 1'b0;
            s_q.gate <= rpc_pkg::GATE_RESET;
            s_q.flags <= rpc_pkg::FLAGS_RESET;
            s_q.rdata <= 8'h00;
            s_q.bandgap_en <= 1'b0;
            s_q.mux_allow <= 1'b1;
            s_q.por_pend <= 1'b1;
            s_q.sleep_off <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign port_reset = port_reset_q;
    assign core_reset = s_q.sys_reset;
    assign brownout_sleep_off = s_q.sleep_off;
    assign detector_off = s_q.detector_off;
    assign gate = s_q.gate;
    assign conv_mux_allow = s_q.mux_allow;
    assign bandgap_enable = s_q.bandgap_en;

endmodule // rpc_reset_power

// >>> bench/rpc_reset_power_properties.sv
// Concurrent checks on the reset and power control ports.
// Assumes binding to rpc_reset_power; everything sits in the mclk domain.
`timescale 1ns/10ps

module rpc_reset_power_properties (
    input wire logic mclk,
    input wire logic rst,
    input wire rpc_pkg::rpc_bus_req_t bus_req,
    input wire logic [7:0] rdata,
    input wire logic ext_reset_n,
    input wire logic scan_reset,
    input wire logic wdt_expire,
    input wire logic wdt_enable,
    input wire logic [1:0] brownout_level_fuse,
    input wire logic comparator_bandgap_select,
    input wire logic converter_enable,
    input wire logic sleep_exec,
    input wire logic core_reset,
    input wire logic port_reset,
    input wire logic brownout_sleep_off,
    input wire logic detector_off,
    input wire rpc_pkg::rpc_gate_t gate,
    input wire logic conv_mux_allow,
    input wire logic bandgap_enable
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    sequence seq_unlock;
        bus_req.wr && bus_req.addr == rpc_pkg::ADDR_CORE_CONTROL && bus_req.wdata[6:5] == 2'h3;
    endsequence
    sequence seq_confirm;
        bus_req.wr && bus_req.addr == rpc_pkg::ADDR_CORE_CONTROL && bus_req.wdata[6:5] == 2'h2
            && !core_reset;
    endsequence
    sequence seq_active;
        brownout_sleep_off [*3] ##1 !brownout_sleep_off;
    endsequence
    AST_SLEEP_OFF_SEQ: assert property (seq_unlock ##[1:4] seq_confirm |-> ##3 seq_active)
        else $error("sleep-off timing wrong");
    AST_SLEEP_OFF_CAUSE: assert property ($rose(brownout_sleep_off) |->
        $past(bus_req.wr && bus_req.addr == 8'h00 && bus_req.wdata[6:5] == 2'h2, 3))
        else $error("sleep-off set without confirm write");
    AST_DETECTOR_OFF: assert property (sleep_exec && brownout_sleep_off |=> detector_off)
        else $error("detector not turned off");
    AST_GATE_RSV: assert property (bus_req.rd && bus_req.addr == 8'h01 |=> rdata[7:5] == 3'h0)
        else $error("reserved gate bits nonzero");
    AST_GATE_WRITE: assert property (bus_req.wr && bus_req.addr == 8'h01 && !core_reset
        |=> gate == $past(bus_req.wdata[4:0]))
        else $error("gate output differs from write");
    AST_MUX_BLOCK: assert property (conv_mux_allow == !gate.converter)
        else $error("mux allowed while converter gated");
    AST_BANDGAP: assert property (!$past(rst) |-> bandgap_enable ==
        $past(brownout_level_fuse != 2'h3 || comparator_bandgap_select || converter_enable))
        else $error("bandgap enable wrong");
    AST_PORT_RESET: assert property (!ext_reset_n |-> port_reset)
        else $error("port reset missing");
    AST_SCAN_HOLD: assert property (scan_reset [*4] |-> core_reset)
        else $error("scan reset not held");
    AST_WDT_RESET: assert property (wdt_expire && wdt_enable && !core_reset |-> ##[1:3] core_reset)
        else $error("watchdog reset missing");
endmodule // rpc_reset_power_properties

bind rpc_reset_power rpc_reset_power_properties u_rpc_reset_power_properties (
    .mclk(mclk), .rst(rst), .bus_req(bus_req), .rdata(rdata), .ext_reset_n(ext_reset_n),
    .scan_reset(scan_reset), .wdt_expire(wdt_expire), .wdt_enable(wdt_enable),
    .brownout_level_fuse(brownout_level_fuse), .comparator_bandgap_select(comparator_bandgap_select),
    .converter_enable(converter_enable), .sleep_exec(sleep_exec), .core_reset(core_reset),
    .port_reset(port_reset), .brownout_sleep_off(brownout_sleep_off), .detector_off(detector_off),
    .gate(gate), .conv_mux_allow(conv_mux_allow), .bandgap_enable(bandgap_enable));

// >>> bench/rpc_reset_power_tb.sv
// Self-checking bench for the reset and power control block.
// Assumes the bench drives every port; read results are checked from a queue.
`timescale 1ns/10ps

module rpc_reset_power_tb;
    logic mclk, rst, ext_reset_n, bod_low, scan_reset, wdt_expire, wdt_enable;
    logic [1:0] brownout_level_fuse, startup_time_fuse;
    logic [3:0] clock_select_fuse;
    logic comparator_bandgap_select, converter_enable, sleep_exec, sleep_wake;
    logic port_reset, core_reset, brownout_sleep_off, detector_off, conv_mux_allow, bandgap_enable;
    logic [7:0] rdata;
    rpc_pkg::rpc_bus_req_t bus_req;
    rpc_pkg::rpc_gate_t gate;
    logic [7:0] exp_q[$];
    logic [7:0] flag_tab[4] = '{8'h02, 8'h04, 8'h10, 8'h08};
    logic rd_seen = 1'b0;
    int fail_count = 0;
    int n_tests = 0;
    logic [31:0] r;
    int dly;

    rpc_reset_power u_rpc_reset_power (.mclk(mclk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
        .ext_reset_n(ext_reset_n), .bod_low(bod_low), .scan_reset(scan_reset),
        .wdt_expire(wdt_expire), .wdt_enable(wdt_enable), .brownout_level_fuse(brownout_level_fuse),
        .startup_time_fuse(startup_time_fuse), .clock_select_fuse(clock_select_fuse),
        .comparator_bandgap_select(comparator_bandgap_select), .converter_enable(converter_enable),
        .sleep_exec(sleep_exec), .sleep_wake(sleep_wake), .port_reset(port_reset),
        .core_reset(core_reset), .brownout_sleep_off(brownout_sleep_off),
        .detector_off(detector_off), .gate(gate), .conv_mux_allow(conv_mux_allow),
        .bandgap_enable(bandgap_enable));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task chk(string n, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (e !== g) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task summarize;
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task bus(logic [7:0] a, logic [7:0] d, logic w, logic rd);
        @(posedge mclk);
        bus_req <= {a, d, w, rd};
    endtask

    task rdx(logic [7:0] a, logic [7:0] e);
        bus(a, 8'h00, 1'b0, 1'b1);
        exp_q.push_back(e);
        bus(8'h00, 8'h00, 1'b0, 1'b0);
    endtask

    task wait_cr(logic v, int lim);
        for (int i = 0; i < lim && core_reset !== v; i++) @(posedge mclk);
        chk("core_reset", {7'h00, v}, {7'h00, core_reset});
    endtask

    task quiet;
        bus(8'h00, 8'h00, 1'b0, 1'b0);
        repeat (7) begin
            @(posedge mclk);
            chk("sleep_off", 8'h00, {7'h00, brownout_sleep_off});
        end
    endtask

    always @(posedge mclk) begin
        if (rd_seen) chk("rdata", exp_q.pop_front(), rdata);
        rd_seen <= bus_req.rd;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        summarize();
    end

    initial begin
        {rst, ext_reset_n, wdt_enable} = 3'h7;
        {bod_low, scan_reset, wdt_expire, sleep_exec, sleep_wake} = 5'h00;
        {comparator_bandgap_select, converter_enable} = 2'h0;
        {brownout_level_fuse, startup_time_fuse, clock_select_fuse} = 8'hC0;
        bus_req = '0;
        r = $urandom(32'hA861);
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        wait_cr(1'b0, 20);
        rdx(8'h01, 8'h00);
        rdx(8'h02, 8'h01);
        rdx(8'h00, 8'h00);
        rdx(8'h07, 8'h00);
        for (int i = 0; i < 8; i++) begin
            r = $urandom;
            {comparator_bandgap_select, converter_enable} <= r[9:8];
            bus(8'h01, r[7:0], 1'b1, 1'b0);
            rdx(8'h01, {3'h0, r[4:0]});
            chk("gate", {3'h0, r[4:0]}, {3'h0, gate});
            chk("mux_allow", {7'h00, ~r[0]}, {7'h00, conv_mux_allow});
            chk("bandgap", {7'h00, r[9] | r[8]}, {7'h00, bandgap_enable});
        end
        bus(8'h00, 8'h40, 1'b1, 1'b0);
        quiet();
        bus(8'h00, 8'h60, 1'b1, 1'b0);
        rdx(8'h00, 8'h20);
        repeat (2) bus(8'h00, 8'h00, 1'b0, 1'b0);
        bus(8'h00, 8'h40, 1'b1, 1'b0);
        quiet();
        bus(8'h00, 8'h60, 1'b1, 1'b0);
        repeat (3) bus(8'h00, 8'h00, 1'b0, 1'b0);
        bus(8'h00, 8'h40, 1'b1, 1'b0);
        repeat (3) bus(8'h00, 8'h00, 1'b0, 1'b0);
        #1 chk("sleep_off", 8'h01, {7'h00, brownout_sleep_off});
        @(posedge mclk) sleep_exec <= 1'b1;
        @(posedge mclk) sleep_exec <= 1'b0;
        #1 chk("detector_off", 8'h01, {7'h00, detector_off});
        repeat (2) @(posedge mclk);
        #1 chk("sleep_off", 8'h00, {7'h00, brownout_sleep_off});
        @(posedge mclk) sleep_wake <= 1'b1;
        @(posedge mclk) sleep_wake <= 1'b0;
        brownout_level_fuse <= 2'h0;
        {comparator_bandgap_select, converter_enable} <= 2'h0;
        #1 chk("detector_off", 8'h00, {7'h00, detector_off});
        bus(8'h02, 8'h00, 1'b1, 1'b0);
        rdx(8'h02, 8'h00);
        chk("bandgap", 8'h01, {7'h00, bandgap_enable});
        for (int k = 0; k < 4; k++) begin
            bus(8'h01, 8'h1F, 1'b1, 1'b0);
            @(posedge mclk);
            case (k)
                0: ext_reset_n <= 1'b0;
                1: bod_low <= 1'b1;
                2: scan_reset <= 1'b1;
                default: wdt_expire <= 1'b1;
            endcase
            clock_select_fuse <= 4'(k);
            startup_time_fuse <= 2'(k >> 1);
            bus_req.wr <= 1'b0;
            dly = (k == 0) ? int'(rpc_pkg::DELAY_EXTCLK) : (k == 1) ? int'(rpc_pkg::DELAY_SUT0)
                : int'(rpc_pkg::DELAY_SUT1);
            #1 if (k < 3) chk("port_reset", 8'h01, {7'h00, port_reset});
            repeat (5) @(posedge mclk);
            chk("core_reset", 8'h01, {7'h00, core_reset});
            {bod_low, scan_reset, wdt_expire, ext_reset_n} <= 4'h1;
            repeat (dly) @(posedge mclk);
            chk("core_reset", 8'h01, {7'h00, core_reset});
            wait_cr(1'b0, 8);
            rdx(8'h01, 8'h00);
            rdx(8'h02, flag_tab[k]);
            bus(8'h02, 8'h00, 1'b1, 1'b0);
        end
        repeat (2) @(posedge mclk);
        summarize();
    end
endmodule // rpc_reset_power_tb
